// ---- core/perf_counter_pkg.sv ----
// constants for the performance counter global control and status block
package perf_counter_pkg;

  // monitoring version implemented; 3 or below disables the force port
  localparam int ARCH_VERSION = 4;
  localparam int GEN_N = 4;
  localparam int FIX_N = 3;
  localparam int CTR_W = 48;

  // model-register addresses
  localparam logic [31:0] GEN_CTR_BASE = 32'h0000_00C1;
  localparam logic [31:0] EVTSEL_BASE = 32'h0000_0186;
  localparam logic [31:0] DEBUG_CTL_ADDR = 32'h0000_01D9;
  localparam logic [31:0] FIX_CTR_BASE = 32'h0000_0309;
  localparam logic [31:0] CAP_ADDR = 32'h0000_0345;
  localparam logic [31:0] FIX_CTRL_ADDR = 32'h0000_038D;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_038E;
  localparam logic [31:0] GLOBAL_CTRL_ADDR = 32'h0000_038F;
  localparam logic [31:0] STATUS_CLEAR_ADDR = 32'h0000_0390;
  localparam logic [31:0] STATUS_FORCE_ADDR = 32'h0000_0391;
  localparam logic [31:0] OCCUPANCY_ADDR = 32'h0000_0392;
  localparam logic [31:0] SAMPLE_EN_ADDR = 32'h0000_03F1;
  localparam logic [31:0] WIDE_ALIAS_BASE = 32'h0000_04C1;
  localparam logic [31:0] ENUM_A_ADDR = 32'h0000_0A00;
  localparam logic [31:0] ENUM_C_ADDR = 32'h0000_0A02;
  localparam logic [31:0] ENUM_D_ADDR = 32'h0000_0A03;

  // event select fields
  localparam int EVSEL_CODE_MSB = 7;
  localparam int EVSEL_INT_BIT = 20;
  localparam int EVSEL_ANY_BIT = 21;
  localparam int EVSEL_EN_BIT = 22;

  // fixed control: 4 bits per counter, enable [1:0], any-thread 2, interrupt 3
  localparam int FIX_FIELD_W = 4;
  localparam int FIX_ANY_OFS = 2;
  localparam int FIX_INT_OFS = 3;

  // debug control bits
  localparam int DBG_FRZ_LBR_BIT = 11;
  localparam int DBG_FRZ_CTR_BIT = 12;

  // status word fields
  localparam int ST_FIX_BASE = 32;
  localparam int ST_LBR_FRZ_BIT = 58;
  localparam int ST_COUNTERS_FROZEN_BIT = 59;
  localparam logic [63:0] STATUS_IMPL = 64'h0C00_0007_0000_000F;
  localparam logic [63:0] LEGACY_CLEAR_MASK = 64'h0000_0007_0000_000F;

  // occupancy fields
  localparam int OCC_FIX_BASE = 32;
  localparam int OCC_INT_BIT = 63;

  // capability word fields
  localparam int CAP_WIDE_WRITE_BIT = 13;
  localparam logic [63:0] CAP_RESET = 64'h0000_0000_0000_2000;

  // enumeration words: version, counts, width, fixed mask, deprecation
  localparam logic [7:0] ENUM_VERSION = 8'h04;
  localparam logic [7:0] ENUM_GEN_COUNT = 8'h04;
  localparam logic [7:0] ENUM_CTR_WIDTH = 8'h30;
  localparam logic [31:0] ENUM_FIX_MASK = 32'h0000_0007;
  localparam logic [4:0] ENUM_FIX_COUNT = 5'h03;
  localparam logic [7:0] ENUM_FIX_WIDTH = 8'h30;
  localparam int ENUM_ANY_DEPRECATED_BIT = 15;

  // reset values
  localparam logic [31:0] EVSEL_RESET = 32'h0000_0000;
  localparam logic [63:0] REG64_RESET = 64'h0000_0000_0000_0000;
  localparam logic [2:0] SYNC_RESET = 3'h0;

endpackage

// ---- core/perf_counter_slice.sv ----
// one loadable performance counter with wrap detection
`timescale 1ns/100ps
`default_nettype none

module perf_counter_slice (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load_en,
  input wire logic [perf_counter_pkg::CTR_W-1:0] load_val,
  input wire logic inc,
  output logic [perf_counter_pkg::CTR_W-1:0] count_q,
  output logic wrap
);

  // a write wins over a count in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_q <= '0;
    end else if (load_en) begin
      count_q <= load_val;
    end else if (inc) begin
      count_q <= count_q + {{(perf_counter_pkg::CTR_W-1){1'b0}}, 1'b1};
    end
  end

  // wrap from all ones to zero
  assign wrap = inc && !load_en && (&count_q);

endmodule
`default_nettype wire

// ---- core/perf_counter_status_inuse.sv ----
// global control, overflow status and occupancy logic for the core counters
//
// How it works
// RL1 - up to version 3, status bits clear only through the legacy clear register.
// RL2 - from version 4, separate clear and force ports act per status bit.
// RL3 - clear port shares the legacy address and bits, adds freeze bit clears.
// RL4 - a one written to the force port sets that status bit.
// RL5 - occupancy bit n is one when event select n code [7:0] is nonzero.
// RL6 - occupancy bits 32..34 reflect fixed control fields [1:0], [5:4], [9:8].
// RL7 - occupancy bit 63 shows any interrupt enable or sampling enable set.
// RL8 - no counter increments while the processor is outside C0.
// RL9 - primary counter write loads low 32 data bits sign-extended.
// RL10 - capability word bit 13 reports full-width write support.
// RL11 - full-width aliases start at 4C1H for counter zero, consecutive.
// RL12 - alias write loads bits 31:0 from low word, upper bits from high word.
// RL13 - fixed counter support is reported as a mask plus a count.
// RL14 - any-thread deprecation is reported at bit 15 of the fourth word.
// RL15 - event select bit 21 selects own-thread or any-thread event counting.
// RL16 - freeze bit 59 sets on interrupt overflow when enabled; freezes counters.
// RL17 - zero bits and unimplemented bits written to clear or force do nothing.
// RL18 - occupancy is combinational from controls; writes to it are ignored.
`timescale 1ns/100ps
`default_nettype none

module perf_counter_status_inuse (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic msr_wr_en,
  input wire logic msr_rd_en,
  input wire logic [31:0] msr_addr,
  input wire logic [63:0] msr_wdata,
  input wire logic [perf_counter_pkg::GEN_N-1:0] gen_event_own,
  input wire logic [perf_counter_pkg::GEN_N-1:0] gen_event_any,
  input wire logic [perf_counter_pkg::FIX_N-1:0] fix_event_own,
  input wire logic [perf_counter_pkg::FIX_N-1:0] fix_event_any,
  input wire logic c0_active,
  output logic [63:0] msr_rdata_q,
  output logic msr_rd_valid_q,
  output logic msr_fault_q,
  output logic overflow_irq_q,
  output logic counters_frozen_q
);

  localparam int GEN_N = perf_counter_pkg::GEN_N;
  localparam int FIX_N = perf_counter_pkg::FIX_N;
  localparam int CTR_W = perf_counter_pkg::CTR_W;
  localparam int FW = perf_counter_pkg::FIX_FIELD_W;

  // control registers
  logic [31:0] evtsel_q [GEN_N];
  logic [63:0] global_ctrl_q;
  logic [63:0] fixed_ctrl_q;
  logic [63:0] sample_en_q;
  logic [63:0] debug_ctl_q;
  logic [63:0] status_q;
  logic [63:0] status_d;
  logic [63:0] occupancy;
  logic [2:0] c0_sync_q;
  logic in_c0_q;

  // counter datapath
  logic [CTR_W-1:0] gen_count [GEN_N];
  logic [CTR_W-1:0] fix_count [FIX_N];
  logic [CTR_W-1:0] gen_load_val [GEN_N];
  logic [GEN_N-1:0] gen_load;
  logic [GEN_N-1:0] gen_wrap;
  logic [GEN_N-1:0] gen_inc;
  logic [GEN_N-1:0] gen_hit_main;
  logic [GEN_N-1:0] gen_hit_alias;
  logic [GEN_N-1:0] evsel_hit;
  logic [FIX_N-1:0] fix_load;
  logic [FIX_N-1:0] fix_wrap;
  logic [FIX_N-1:0] fix_inc;
  logic [FIX_N-1:0] fix_hit;
  logic [GEN_N-1:0] gen_int_en;
  logic [FIX_N-1:0] fix_int_en;

  // overflow events
  logic [63:0] hw_set;
  logic irq_overflow;
  logic counting_ok;

  // decode helpers
  logic wide_write_ok;
  logic force_mapped;
  logic hit_any;
  logic [63:0] rd_mux;
  logic [63:0] clear_mask;
  logic [63:0] cap_word;
  logic [63:0] enum_a;
  logic [63:0] enum_c;
  logic [63:0] enum_d;

  // capability and enumeration words are constant
  assign cap_word = perf_counter_pkg::CAP_RESET; // [RL10]
  assign wide_write_ok = cap_word[perf_counter_pkg::CAP_WIDE_WRITE_BIT];
  assign enum_a = {32'h0000_0000, perf_counter_pkg::ENUM_CTR_WIDTH,
                   perf_counter_pkg::ENUM_GEN_COUNT, perf_counter_pkg::ENUM_VERSION,
                   8'h00};
  assign enum_c = {32'h0000_0000, perf_counter_pkg::ENUM_FIX_MASK}; // [RL13]
  assign enum_d = {48'h0000_0000_0000, 1'b1, 2'h0, perf_counter_pkg::ENUM_FIX_WIDTH,
                   perf_counter_pkg::ENUM_FIX_COUNT}; // [RL14] [RL13]

  // legacy versions clear only the older overflow bits
  assign clear_mask = (perf_counter_pkg::ARCH_VERSION >= 4) ?
                      perf_counter_pkg::STATUS_IMPL :
                      perf_counter_pkg::LEGACY_CLEAR_MASK; // [RL1] [RL3]
  assign force_mapped = (perf_counter_pkg::ARCH_VERSION >= 4); // [RL2]

  // outside-domain power state passes three flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      c0_sync_q <= perf_counter_pkg::SYNC_RESET;
    end else begin
      c0_sync_q <= {c0_sync_q[1:0], c0_active};
    end
  end

  // power state accepted only when the last two stages agree
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      in_c0_q <= 1'b0;
    end else if (c0_sync_q[1] == c0_sync_q[2]) begin
      in_c0_q <= c0_sync_q[2];
    end
  end

  // counting needs C0 and no freeze indication
  assign counting_ok = in_c0_q && !status_q[perf_counter_pkg::ST_COUNTERS_FROZEN_BIT]; // [RL8] [RL16]

  // general counters with their event selects
  genvar n;
  generate
    for (n = 0; n < GEN_N; n++) begin : g_gen
      logic ev_sel;
      assign gen_hit_main[n] = (msr_addr == perf_counter_pkg::GEN_CTR_BASE + n);
      assign gen_hit_alias[n] = wide_write_ok &&
                                (msr_addr == perf_counter_pkg::WIDE_ALIAS_BASE + n); // [RL11]
      assign evsel_hit[n] = (msr_addr == perf_counter_pkg::EVTSEL_BASE + n);
      assign gen_load[n] = msr_wr_en && (gen_hit_main[n] || gen_hit_alias[n]);
      // primary address sign-extends, alias takes the upper word too
      assign gen_load_val[n] = gen_hit_alias[n] ?
                               {msr_wdata[CTR_W-1:32], msr_wdata[31:0]} : // [RL12]
                               {{(CTR_W-32){msr_wdata[31]}}, msr_wdata[31:0]}; // [RL9]
      assign ev_sel = evtsel_q[n][perf_counter_pkg::EVSEL_ANY_BIT] ?
                      gen_event_any[n] : gen_event_own[n]; // [RL15]
      assign gen_inc[n] = ev_sel && evtsel_q[n][perf_counter_pkg::EVSEL_EN_BIT] &&
                          global_ctrl_q[n] && counting_ok; // [RL8]
      assign gen_int_en[n] = evtsel_q[n][perf_counter_pkg::EVSEL_INT_BIT];

      // event select storage
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          evtsel_q[n] <= perf_counter_pkg::EVSEL_RESET;
        end else if (msr_wr_en && evsel_hit[n]) begin
          evtsel_q[n] <= msr_wdata[31:0];
        end
      end

      perf_counter_slice u_ctr (
        .clk(clk),
        .rst_b(rst_b),
        .load_en(gen_load[n]),
        .load_val(gen_load_val[n]),
        .inc(gen_inc[n]),
        .count_q(gen_count[n]),
        .wrap(gen_wrap[n])
      );
    end
  endgenerate

  // fixed counters controlled by one packed control register
  genvar i;
  generate
    for (i = 0; i < FIX_N; i++) begin : g_fix
      logic ev_sel;
      assign fix_hit[i] = (msr_addr == perf_counter_pkg::FIX_CTR_BASE + i);
      assign fix_load[i] = msr_wr_en && fix_hit[i];
      assign ev_sel = fixed_ctrl_q[FW*i + perf_counter_pkg::FIX_ANY_OFS] ?
                      fix_event_any[i] : fix_event_own[i];
      assign fix_inc[i] = ev_sel && (|fixed_ctrl_q[FW*i +: 2]) &&
                          global_ctrl_q[perf_counter_pkg::ST_FIX_BASE + i] &&
                          counting_ok; // [RL8]
      assign fix_int_en[i] = fixed_ctrl_q[FW*i + perf_counter_pkg::FIX_INT_OFS];

      perf_counter_slice u_ctr (
        .clk(clk),
        .rst_b(rst_b),
        .load_en(fix_load[i]),
        .load_val(msr_wdata[CTR_W-1:0]),
        .inc(fix_inc[i]),
        .count_q(fix_count[i]),
        .wrap(fix_wrap[i])
      );
    end
  endgenerate

  // overflow bits and freeze indications raised by hardware
  always_comb begin
    hw_set = '0;
    hw_set[GEN_N-1:0] = gen_wrap;
    hw_set[perf_counter_pkg::ST_FIX_BASE +: FIX_N] = fix_wrap;
    irq_overflow = |(gen_wrap & gen_int_en) || |(fix_wrap & fix_int_en);
    hw_set[perf_counter_pkg::ST_COUNTERS_FROZEN_BIT] =
      irq_overflow && debug_ctl_q[perf_counter_pkg::DBG_FRZ_CTR_BIT]; // [RL16]
    hw_set[perf_counter_pkg::ST_LBR_FRZ_BIT] =
      irq_overflow && debug_ctl_q[perf_counter_pkg::DBG_FRZ_LBR_BIT];
  end

  // status next value: clear by ones only, then force and hardware set win
  always_comb begin
    status_d = status_q;
    if (msr_wr_en && msr_addr == perf_counter_pkg::STATUS_CLEAR_ADDR) begin
      status_d = status_d & ~(msr_wdata & clear_mask); // [RL1] [RL3] [RL17]
    end
    if (msr_wr_en && force_mapped && msr_addr == perf_counter_pkg::STATUS_FORCE_ADDR) begin
      status_d = status_d | (msr_wdata & perf_counter_pkg::STATUS_IMPL); // [RL4] [RL17]
    end
    status_d = (status_d | hw_set) & perf_counter_pkg::STATUS_IMPL; // [RL2]
  end

  // overflow status word
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_q <= perf_counter_pkg::REG64_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // global enables, fixed control, sampling enables and debug control
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      global_ctrl_q <= perf_counter_pkg::REG64_RESET;
      fixed_ctrl_q <= perf_counter_pkg::REG64_RESET;
      sample_en_q <= perf_counter_pkg::REG64_RESET;
      debug_ctl_q <= perf_counter_pkg::REG64_RESET;
    end else if (msr_wr_en) begin
      if (msr_addr == perf_counter_pkg::GLOBAL_CTRL_ADDR) begin
        global_ctrl_q <= msr_wdata & perf_counter_pkg::LEGACY_CLEAR_MASK;
      end
      if (msr_addr == perf_counter_pkg::FIX_CTRL_ADDR) begin
        fixed_ctrl_q <= {52'h0_0000_0000_0000, msr_wdata[11:0]};
      end
      if (msr_addr == perf_counter_pkg::SAMPLE_EN_ADDR) begin
        sample_en_q <= msr_wdata & perf_counter_pkg::LEGACY_CLEAR_MASK;
      end
      if (msr_addr == perf_counter_pkg::DEBUG_CTL_ADDR) begin
        debug_ctl_q <= msr_wdata;
      end
    end
  end

  // occupancy reflects controls directly, nothing stored
  always_comb begin
    occupancy = '0;
    for (int k = 0; k < GEN_N; k++) begin
      occupancy[k] = |evtsel_q[k][perf_counter_pkg::EVSEL_CODE_MSB:0]; // [RL5] [RL18]
    end
    for (int k = 0; k < FIX_N; k++) begin
      occupancy[perf_counter_pkg::OCC_FIX_BASE + k] = |fixed_ctrl_q[FW*k +: 2]; // [RL6]
    end
    occupancy[perf_counter_pkg::OCC_INT_BIT] = |gen_int_en || |fix_int_en ||
                                               |sample_en_q; // [RL7]
  end

  // read mux and address hit
  always_comb begin
    rd_mux = '0;
    hit_any = 1'b0;
    for (int k = 0; k < GEN_N; k++) begin
      if (gen_hit_main[k] || gen_hit_alias[k]) begin
        rd_mux = {{(64-CTR_W){1'b0}}, gen_count[k]};
        hit_any = 1'b1;
      end
      if (evsel_hit[k]) begin
        rd_mux = {32'h0000_0000, evtsel_q[k]};
        hit_any = 1'b1;
      end
    end
    for (int k = 0; k < FIX_N; k++) begin
      if (fix_hit[k]) begin
        rd_mux = {{(64-CTR_W){1'b0}}, fix_count[k]};
        hit_any = 1'b1;
      end
    end
    case (msr_addr)
      perf_counter_pkg::STATUS_ADDR: begin
        rd_mux = status_q;
        hit_any = 1'b1;
      end
      perf_counter_pkg::GLOBAL_CTRL_ADDR: begin
        rd_mux = global_ctrl_q;
        hit_any = 1'b1;
      end
      perf_counter_pkg::FIX_CTRL_ADDR: begin
        rd_mux = fixed_ctrl_q;
        hit_any = 1'b1;
      end
      perf_counter_pkg::SAMPLE_EN_ADDR: begin
        rd_mux = sample_en_q;
        hit_any = 1'b1;
      end
      perf_counter_pkg::DEBUG_CTL_ADDR: begin
        rd_mux = debug_ctl_q;
        hit_any = 1'b1;
      end
      perf_counter_pkg::OCCUPANCY_ADDR: begin
        rd_mux = occupancy; // [RL18]
        hit_any = 1'b1;
      end
      perf_counter_pkg::STATUS_CLEAR_ADDR: begin
        hit_any = 1'b1;
      end
      perf_counter_pkg::STATUS_FORCE_ADDR: begin
        hit_any = force_mapped;
      end
      perf_counter_pkg::CAP_ADDR: begin
        rd_mux = cap_word;
        hit_any = 1'b1;
      end
      perf_counter_pkg::ENUM_A_ADDR: begin
        rd_mux = enum_a;
        hit_any = 1'b1;
      end
      perf_counter_pkg::ENUM_C_ADDR: begin
        rd_mux = enum_c;
        hit_any = 1'b1;
      end
      perf_counter_pkg::ENUM_D_ADDR: begin
        rd_mux = enum_d;
        hit_any = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // registered read answer and unmapped-access fault, one cycle later
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      msr_rdata_q <= perf_counter_pkg::REG64_RESET;
      msr_rd_valid_q <= 1'b0;
      msr_fault_q <= 1'b0;
    end else begin
      msr_rd_valid_q <= msr_rd_en;
      msr_fault_q <= (msr_rd_en || msr_wr_en) && !hit_any;
      if (msr_rd_en) begin
        msr_rdata_q <= rd_mux;
      end
    end
  end

  // interrupt pulse and freeze level outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      overflow_irq_q <= 1'b0;
      counters_frozen_q <= 1'b0;
    end else begin
      overflow_irq_q <= irq_overflow;
      counters_frozen_q <= status_d[perf_counter_pkg::ST_COUNTERS_FROZEN_BIT]; // [RL16]
    end
  end

endmodule
`default_nettype wire

// ---- sim/perf_counter_status_inuse_assertions.sv ----
// port-level checks for the counter control and status block
`timescale 1ns/100ps
`default_nettype none

module perf_counter_status_inuse_assertions (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic msr_wr_en,
  input wire logic msr_rd_en,
  input wire logic [31:0] msr_addr,
  input wire logic [63:0] msr_wdata,
  input wire logic [perf_counter_pkg::GEN_N-1:0] gen_event_own,
  input wire logic [perf_counter_pkg::GEN_N-1:0] gen_event_any,
  input wire logic [63:0] msr_rdata_q,
  input wire logic msr_rd_valid_q,
  input wire logic msr_fault_q,
  input wire logic counters_frozen_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // steps of a write followed by a status or occupancy read
  sequence s_evsel0_code;
    msr_wr_en && msr_addr == perf_counter_pkg::EVTSEL_BASE && msr_wdata[7:0] != 8'h00;
  endsequence
  sequence s_force0;
    msr_wr_en && msr_addr == perf_counter_pkg::STATUS_FORCE_ADDR && msr_wdata[0];
  endsequence
  sequence s_clear0;
    msr_wr_en && msr_addr == perf_counter_pkg::STATUS_CLEAR_ADDR && msr_wdata[0];
  endsequence
  sequence s_occ_read;
    msr_rd_en && msr_addr == perf_counter_pkg::OCCUPANCY_ADDR;
  endsequence
  sequence s_st_read;
    msr_rd_en && msr_addr == perf_counter_pkg::STATUS_ADDR && gen_event_own == 4'h0
      && gen_event_any == 4'h0;
  endsequence

  a_read_answer: assert property (msr_rd_en |=> msr_rd_valid_q || msr_fault_q)
    else $error("read strobe got no answer");
  a_valid_cause: assert property (msr_rd_valid_q |-> $past(msr_rd_en))
    else $error("read valid without a read");
  a_rdata_holds: assert property (!msr_rd_valid_q && !msr_fault_q |-> $stable(msr_rdata_q))
    else $error("read data moved without a read");
  a_occ_code: assert property (s_evsel0_code ##1 !msr_wr_en ##1 s_occ_read |=> msr_rdata_q[0])
    else $error("occupancy bit 0 not set");
  a_force_sets: assert property (s_force0 ##1 !msr_wr_en ##1 s_st_read |=> msr_rdata_q[0])
    else $error("force did not set status bit 0");
  a_clear_zeroes: assert property (s_clear0 ##1 !msr_wr_en ##1 s_st_read |=> !msr_rdata_q[0])
    else $error("clear did not clear status bit 0");
  a_frozen_stays: assert property (counters_frozen_q && !msr_wr_en && !$past(msr_wr_en) |=> counters_frozen_q)
    else $error("freeze dropped without a write");
  a_cap_wide: assert property (msr_rd_en && msr_addr == perf_counter_pkg::CAP_ADDR |=> msr_rdata_q[13])
    else $error("wide write capability not reported");
  a_enum_deprecated: assert property (msr_rd_en && msr_addr == perf_counter_pkg::ENUM_D_ADDR |=> msr_rdata_q[15])
    else $error("any-thread deprecation not reported");
endmodule

`default_nettype wire

// ---- sim/perf_counter_status_inuse_tb.sv ----
// self-checking bench for the counter control and status block
`timescale 1ns/100ps
`default_nettype none

module perf_counter_status_inuse_tb;
  localparam logic [31:0] ST_A = perf_counter_pkg::STATUS_ADDR;
  localparam logic [31:0] CLR_A = perf_counter_pkg::STATUS_CLEAR_ADDR;
  localparam logic [31:0] OCC_A = perf_counter_pkg::OCCUPANCY_ADDR;
  localparam logic [31:0] EV_A = perf_counter_pkg::EVTSEL_BASE;
  localparam logic [31:0] GEN_A = perf_counter_pkg::GEN_CTR_BASE;
  localparam logic [31:0] ALI_A = perf_counter_pkg::WIDE_ALIAS_BASE;
  localparam logic [31:0] FXC_A = perf_counter_pkg::FIX_CTRL_ADDR;
  localparam logic [31:0] SMP_A = perf_counter_pkg::SAMPLE_EN_ADDR;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic msr_wr_en = 1'b0;
  logic msr_rd_en = 1'b0;
  logic [31:0] msr_addr = 32'h0;
  logic [63:0] msr_wdata = 64'h0;
  logic [3:0] gen_event_own = 4'h0;
  logic [3:0] gen_event_any = 4'h0;
  logic [2:0] fix_event_own = 3'h0;
  logic [2:0] fix_event_any = 3'h0;
  logic c0_active = 1'b1;
  logic [63:0] msr_rdata_q;
  logic msr_rd_valid_q, msr_fault_q, overflow_irq_q, counters_frozen_q;
  int num_errors = 0;
  int checks_done = 0;
  int irq_count = 0;

  perf_counter_status_inuse u_perf_counter_status_inuse (.clk(clk), .rst_b(rst_b),
    .msr_wr_en(msr_wr_en), .msr_rd_en(msr_rd_en), .msr_addr(msr_addr), .msr_wdata(msr_wdata),
    .gen_event_own(gen_event_own), .gen_event_any(gen_event_any),
    .fix_event_own(fix_event_own), .fix_event_any(fix_event_any), .c0_active(c0_active),
    .msr_rdata_q(msr_rdata_q), .msr_rd_valid_q(msr_rd_valid_q), .msr_fault_q(msr_fault_q),
    .overflow_irq_q(overflow_irq_q), .counters_frozen_q(counters_frozen_q));

  // 25 MHz core clock
  always #20 clk = ~clk;

  // count interrupt pulses
  always @(posedge clk) begin
    if (overflow_irq_q === 1'b1) irq_count++;
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [63:0] d);
    @(posedge clk);
    msr_wr_en <= 1'b1;
    msr_addr <= a;
    msr_wdata <= d;
    @(posedge clk);
    msr_wr_en <= 1'b0;
  endtask

  // read, then compare data and the fault flag
  task automatic rdc(input logic [31:0] a, input logic [63:0] e, input logic f);
    @(posedge clk);
    msr_rd_en <= 1'b1;
    msr_addr <= a;
    @(posedge clk);
    msr_rd_en <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, msr_rdata_q);
    chk("fault", {63'h0, f}, {63'h0, msr_fault_q});
    if (!f) chk("valid", 64'h1, {63'h0, msr_rd_valid_q});
  endtask

  task automatic pulse(input logic [3:0] own, input logic [3:0] any);
    @(posedge clk);
    gen_event_own <= own;
    gen_event_any <= any;
    @(posedge clk);
    gen_event_own <= 4'h0;
    gen_event_any <= 4'h0;
  endtask

  task automatic occ_step(input logic [31:0] a, input logic [63:0] d, input logic [63:0] e);
    wr(a, d);
    rdc(OCC_A, e, 1'b0);
  endtask

  task automatic t_status;
    wr(perf_counter_pkg::STATUS_FORCE_ADDR, 64'hFFFF_FFFF_FFFF_FFFF);
    rdc(ST_A, perf_counter_pkg::STATUS_IMPL, 1'b0);
    chk("frozen", 64'h1, {63'h0, counters_frozen_q});
    wr(CLR_A, 64'h0);
    rdc(ST_A, perf_counter_pkg::STATUS_IMPL, 1'b0);
    wr(CLR_A, 64'h0800_0000_0000_0001);
    rdc(ST_A, perf_counter_pkg::STATUS_IMPL & 64'hF7FF_FFFF_FFFF_FFFE, 1'b0);
    chk("frozen", 64'h0, {63'h0, counters_frozen_q});
    wr(CLR_A, 64'hFFFF_FFFF_FFFF_FFFF);
    rdc(ST_A, 64'h0, 1'b0);
    rdc(CLR_A, 64'h0, 1'b0);
    $display("status test done");
  endtask

  task automatic t_occ;
    occ_step(EV_A, 64'h1, 64'h1);
    occ_step(EV_A + 32'h3, 64'h80, 64'h9);
    occ_step(FXC_A, 64'h311, 64'h0000_0007_0000_0009);
    occ_step(OCC_A, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0000_0007_0000_0009);
    occ_step(EV_A + 32'h3, 64'h0010_0000, 64'h8000_0007_0000_0001);
    occ_step(EV_A + 32'h3, 64'h0, 64'h0000_0007_0000_0001);
    occ_step(SMP_A, 64'h1, 64'h8000_0007_0000_0001);
    occ_step(SMP_A, 64'h0, 64'h0000_0007_0000_0001);
    occ_step(FXC_A, 64'h801, 64'h8000_0001_0000_0001);
    occ_step(FXC_A, 64'h0, 64'h1);
    occ_step(EV_A, 64'h0, 64'h0);
    $display("occupancy test done");
  endtask

  task automatic t_wide;
    wr(GEN_A + 32'h1, 64'hAAAA_BBBB_8000_0001);
    rdc(GEN_A + 32'h1, 64'h0000_FFFF_8000_0001, 1'b0);
    wr(GEN_A + 32'h1, 64'hAAAA_BBBB_7FFF_FFFF);
    rdc(GEN_A + 32'h1, 64'h7FFF_FFFF, 1'b0);
    wr(ALI_A + 32'h2, 64'hFFFF_1234_5678_9ABC);
    rdc(GEN_A + 32'h2, 64'h0000_1234_5678_9ABC, 1'b0);
    wr(ALI_A + 32'h3, 64'h8000_0000);
    rdc(GEN_A + 32'h3, 64'h8000_0000, 1'b0);
    $display("wide write test done");
  endtask

  task automatic t_caps;
    rdc(perf_counter_pkg::CAP_ADDR, perf_counter_pkg::CAP_RESET, 1'b0);
    wr(perf_counter_pkg::CAP_ADDR, 64'h0);
    rdc(perf_counter_pkg::CAP_ADDR, perf_counter_pkg::CAP_RESET, 1'b0);
    rdc(perf_counter_pkg::ENUM_A_ADDR, 64'h3004_0400, 1'b0);
    rdc(perf_counter_pkg::ENUM_C_ADDR, 64'h7, 1'b0);
    rdc(perf_counter_pkg::ENUM_D_ADDR, 64'h8603, 1'b0);
    rdc(32'h0000_0ABC, 64'h0, 1'b1);
    // a write to an unmapped address is refused with a fault pulse
    wr(32'h0000_0ABC, 64'h1);
    #1;
    chk("write fault", 64'h1, {63'h0, msr_fault_q});
    $display("capability test done");
  endtask

  // count, stop outside C0, overflow with freeze, thread qualification
  task automatic t_count;
    wr(perf_counter_pkg::GLOBAL_CTRL_ADDR, 64'h3);
    wr(perf_counter_pkg::DEBUG_CTL_ADDR, 64'h1000);
    wr(EV_A, 64'h0050_0001);
    wr(ALI_A, 64'h0000_FFFF_FFFF_FFFE);
    pulse(4'h1, 4'h0);
    rdc(GEN_A, 64'h0000_FFFF_FFFF_FFFF, 1'b0);
    @(posedge clk);
    c0_active <= 1'b0;
    repeat (6) @(posedge clk);
    pulse(4'h1, 4'h0);
    rdc(GEN_A, 64'h0000_FFFF_FFFF_FFFF, 1'b0);
    @(posedge clk);
    c0_active <= 1'b1;
    repeat (6) @(posedge clk);
    pulse(4'h1, 4'h0);
    repeat (3) @(posedge clk);
    chk("irq pulses", 64'h1, 64'(irq_count));
    rdc(ST_A, 64'h0800_0000_0000_0001, 1'b0);
    chk("frozen", 64'h1, {63'h0, counters_frozen_q});
    pulse(4'h1, 4'h0);
    rdc(GEN_A, 64'h0, 1'b0);
    wr(CLR_A, 64'hFFFF_FFFF_FFFF_FFFF);
    wr(EV_A + 32'h1, 64'h0060_0001);
    pulse(4'h2, 4'h0);
    pulse(4'h0, 4'h2);
    rdc(GEN_A + 32'h1, 64'h8000_0000, 1'b0);
    // fixed counter 0 wraps with its interrupt enabled, then stays frozen
    wr(CLR_A, 64'hFFFF_FFFF_FFFF_FFFF);
    wr(perf_counter_pkg::GLOBAL_CTRL_ADDR, 64'h0000_0001_0000_0000);
    wr(FXC_A, 64'h9);
    wr(perf_counter_pkg::FIX_CTR_BASE, 64'hFFFF_FFFF_FFFF_FFFF);
    @(posedge clk);
    fix_event_own <= 3'h1;
    @(posedge clk);
    fix_event_own <= 3'h0;
    rdc(ST_A, 64'h0800_0001_0000_0000, 1'b0);
    chk("irq pulses", 64'h2, 64'(irq_count));
    @(posedge clk);
    fix_event_own <= 3'h1;
    @(posedge clk);
    fix_event_own <= 3'h0;
    rdc(perf_counter_pkg::FIX_CTR_BASE, 64'h0, 1'b0);
    $display("counting test done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    results();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_status();
    t_occ();
    t_wide();
    t_caps();
    t_count();
    results();
  end
endmodule

bind perf_counter_status_inuse perf_counter_status_inuse_assertions
  u_perf_counter_status_inuse_assertions (.clk(clk), .rst_b(rst_b), .msr_wr_en(msr_wr_en),
  .msr_rd_en(msr_rd_en), .msr_addr(msr_addr), .msr_wdata(msr_wdata),
  .gen_event_own(gen_event_own), .gen_event_any(gen_event_any), .msr_rdata_q(msr_rdata_q),
  .msr_rd_valid_q(msr_rd_valid_q), .msr_fault_q(msr_fault_q),
  .counters_frozen_q(counters_frozen_q));

`default_nettype wire
